// File: common/fsr_defs.svh
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

// ============================================================
// Serial command
`define FSR_BYTE_W          8
`define FSR_OP_STATUS_READ  8'hD7

// ============================================================
// First status byte layout
`define FSR_B1_READY        7
`define FSR_B1_COMPARE      6
`define FSR_B1_DENSITY_HI   5
`define FSR_B1_DENSITY_LO   2
`define FSR_B1_PROTECT      1
`define FSR_B1_PAGE_SIZE    0

// ============================================================
// Second status byte layout
`define FSR_B2_READY        7
`define FSR_B2_UNUSED_HI    6
`define FSR_B2_FAILURE      5
`define FSR_B2_UNUSED_LO    4
`define FSR_B2_LOCKDOWN     3
`define FSR_B2_SUSPEND_BUF2 2
`define FSR_B2_SUSPEND_BUF1 1
`define FSR_B2_ERASE_SUSP   0

// ============================================================
// Reset values
`define FSR_RST_COMPARE     1'h0
`define FSR_RST_FAILURE     1'h0
`define FSR_RST_LOCKDOWN    1'h1
`define FSR_RST_SUSPEND     1'h0
`define FSR_RST_BYTE        8'h00
`define FSR_RST_COUNT       3'h0
`define FSR_LAST_BIT        3'h7

`endif

// File: common/fsr_pkg.sv
`include "fsr_defs.svh"

package fsr_pkg;

  // ============================================================
  // Serial phases while chip select is low
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_OPCODE,
    PH_STATUS,
    PH_IGNORE
  } fsr_phase_t;

  // ============================================================
  // Main block state
  typedef struct packed {
    fsr_phase_t                 phase;
    logic                       sckPrev;
    logic [`FSR_BYTE_W-1:0]     opcode;
    logic [2:0]                 inCnt;
    logic [2:0]                 outCnt;
    logic                       byteSel;
    logic                       loadReq;
    logic                       shiftReq;
    logic                       cmpFlag;
    logic                       failFlag;
    logic                       lockAvail;
    logic                       suspBuf1;
    logic                       suspBuf2;
    logic                       eraseSusp;
    logic [`FSR_BYTE_W-1:0]     firstByte;
    logic [`FSR_BYTE_W-1:0]     secondByte;
  } fsr_state_t;

  // ============================================================
  // Output shifter state
  typedef struct packed {
    logic [`FSR_BYTE_W-1:0]     data;
  } fsr_shift_t;

endpackage : fsr_pkg

// File: design/fsr_byte_shifter.sv
`timescale 1ns/1ps
`include "fsr_defs.svh"

module fsr_byte_shifter (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   load,
  input  wire logic [`FSR_BYTE_W-1:0] loadData,
  input  wire logic                   shift,
  output logic                        serOut
);

  fsr_pkg::fsr_shift_t state_q;
  fsr_pkg::fsr_shift_t state_d;

  // ============================================================
  // Next state: load wins, MSB first
  always_comb begin
    state_d = state_q;
    if (load) begin
      state_d.data = loadData;
    end else if (shift) begin
      state_d.data = {state_q.data[`FSR_BYTE_W-2:0], 1'h0};
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q.data <= `FSR_RST_BYTE;
    end else begin
      state_q <= state_d;
    end
  end

  assign serOut = state_q.data[`FSR_BYTE_W-1];

endmodule : fsr_byte_shifter

// File: design/fsr_flash_status_register.sv
`timescale 1ns/1ps
`include "fsr_defs.svh"

module fsr_flash_status_register #(
  // Arbitrary capacity code value, not the real part's code
  parameter logic [3:0] DENSITY_CODE = 4'hA
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   csN,
  input  wire logic                   sck,
  input  wire logic                   si,
  output logic                        so,
  output logic                        soEn,
  input  wire logic                   opBusy,
  input  wire logic                   opDone,
  input  wire logic                   opFailed,
  input  wire logic                   opAborted,
  input  wire logic                   cmpDone,
  input  wire logic                   cmpMismatch,
  input  wire logic                   protectSw,
  input  wire logic                   protectHw,
  input  wire logic                   pageBinary,
  input  wire logic                   lockFreeze,
  input  wire logic                   progSuspend1,
  input  wire logic                   progResume1,
  input  wire logic                   progSuspend2,
  input  wire logic                   progResume2,
  input  wire logic                   eraseSuspend,
  input  wire logic                   eraseResume,
  input  wire logic                   bufWrReq1,
  input  wire logic                   bufWrReq2,
  output logic                        bufWrAccept1,
  output logic                        bufWrAccept2,
  output logic [`FSR_BYTE_W-1:0]      statusFirst,
  output logic [`FSR_BYTE_W-1:0]      statusSecond
);

  fsr_pkg::fsr_state_t state_q;
  fsr_pkg::fsr_state_t state_d;

  logic                   sckRise;
  logic                   sckFall;
  logic                   protectOn;
  logic [`FSR_BYTE_W-1:0] opcodeNext;
  logic [`FSR_BYTE_W-1:0] loadByte;

  // ============================================================
  // Pin edges; pins are synchronous, so one register suffices
  assign sckRise    = sck & ~state_q.sckPrev;
  assign sckFall    = ~sck & state_q.sckPrev;
  assign opcodeNext = {state_q.opcode[`FSR_BYTE_W-2:0], si};

  // Either protection method counts
  assign protectOn = protectSw | protectHw;

  // ============================================================
  // Next state
  always_comb begin
    state_d          = state_q;
    state_d.sckPrev  = sck;
    state_d.loadReq  = 1'h0;
    state_d.shiftReq = 1'h0;

    // Compare result kept until the next compare finishes
    if (cmpDone) begin
      state_d.cmpFlag = cmpMismatch;
    end

    // An abort reports success, so the flag is never set by it
    if (opDone) begin
      state_d.failFlag = opFailed & ~opAborted;
    end

    // Once frozen, lockdown stays unavailable until reset
    if (lockFreeze) begin
      state_d.lockAvail = 1'h0;
    end

    // Suspend pulses win over a resume in the same cycle
    if (progResume1) begin
      state_d.suspBuf1 = 1'h0;
    end
    if (progSuspend1) begin
      state_d.suspBuf1 = 1'h1;
    end
    if (progResume2) begin
      state_d.suspBuf2 = 1'h0;
    end
    if (progSuspend2) begin
      state_d.suspBuf2 = 1'h1;
    end
    if (eraseResume) begin
      state_d.eraseSusp = 1'h0;
    end
    if (eraseSuspend) begin
      state_d.eraseSusp = 1'h1;
    end

    // ------------------------------------------------------------
    // Serial command decode
    if (csN) begin
      state_d.phase   = fsr_pkg::PH_IDLE;
      state_d.inCnt   = `FSR_RST_COUNT;
      state_d.outCnt  = `FSR_RST_COUNT;
      state_d.byteSel = 1'h0;
    end else begin
      unique case (state_q.phase)
        fsr_pkg::PH_IDLE: begin
          state_d.phase = fsr_pkg::PH_OPCODE;
          if (sckRise) begin
            state_d.opcode = opcodeNext;
            state_d.inCnt  = 3'h1;
          end
        end
        fsr_pkg::PH_OPCODE: begin
          if (sckRise) begin
            state_d.opcode = opcodeNext;
            state_d.inCnt  = state_q.inCnt + 3'h1;
            if (state_q.inCnt == `FSR_LAST_BIT) begin
              // Anything other than the status read is not ours
              if (opcodeNext == `FSR_OP_STATUS_READ) begin
                state_d.phase = fsr_pkg::PH_STATUS;
              end else begin
                state_d.phase = fsr_pkg::PH_IGNORE;
              end
              state_d.outCnt  = `FSR_RST_COUNT;
              state_d.byteSel = 1'h0;
            end
          end
        end
        fsr_pkg::PH_STATUS: begin
          // Each byte is sampled fresh as it starts, so ready may
          // change between bytes while the host polls
          if (sckFall) begin
            state_d.outCnt = state_q.outCnt + 3'h1;
            if (state_q.outCnt == `FSR_RST_COUNT) begin
              state_d.loadReq = 1'h1;
            end else begin
              state_d.shiftReq = 1'h1;
            end
            if (state_q.outCnt == `FSR_LAST_BIT) begin
              state_d.byteSel = ~state_q.byteSel;
            end
          end
        end
        fsr_pkg::PH_IGNORE: begin
          state_d.phase = fsr_pkg::PH_IGNORE;
        end
      endcase
    end

    // Bytes built from the updated flags, inside this process to avoid a loop
    state_d.firstByte                                      = `FSR_RST_BYTE;
    state_d.firstByte[`FSR_B1_READY]                       = ~opBusy;
    state_d.firstByte[`FSR_B1_COMPARE]                     = state_d.cmpFlag;
    state_d.firstByte[`FSR_B1_DENSITY_HI:`FSR_B1_DENSITY_LO] = DENSITY_CODE;
    state_d.firstByte[`FSR_B1_PROTECT]                     = protectOn;
    state_d.firstByte[`FSR_B1_PAGE_SIZE]                   = pageBinary;
    state_d.secondByte                                     = `FSR_RST_BYTE;
    state_d.secondByte[`FSR_B2_READY]                      = ~opBusy;
    state_d.secondByte[`FSR_B2_UNUSED_HI]                  = 1'h0;
    state_d.secondByte[`FSR_B2_FAILURE]                    = state_d.failFlag;
    state_d.secondByte[`FSR_B2_UNUSED_LO]                  = 1'h0;
    state_d.secondByte[`FSR_B2_LOCKDOWN]                   = state_d.lockAvail;
    state_d.secondByte[`FSR_B2_SUSPEND_BUF2]               = state_d.suspBuf2;
    state_d.secondByte[`FSR_B2_SUSPEND_BUF1]               = state_d.suspBuf1;
    state_d.secondByte[`FSR_B2_ERASE_SUSP]                 = state_d.eraseSusp;
  end

  // ============================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q.phase      <= fsr_pkg::PH_IDLE;
      state_q.sckPrev    <= 1'h0;
      state_q.opcode     <= `FSR_RST_BYTE;
      state_q.inCnt      <= `FSR_RST_COUNT;
      state_q.outCnt     <= `FSR_RST_COUNT;
      state_q.byteSel    <= 1'h0;
      state_q.loadReq    <= 1'h0;
      state_q.shiftReq   <= 1'h0;
      state_q.cmpFlag    <= `FSR_RST_COMPARE;
      state_q.failFlag   <= `FSR_RST_FAILURE;
      state_q.lockAvail  <= `FSR_RST_LOCKDOWN;
      state_q.suspBuf1   <= `FSR_RST_SUSPEND;
      state_q.suspBuf2   <= `FSR_RST_SUSPEND;
      state_q.eraseSusp  <= `FSR_RST_SUSPEND;
      state_q.firstByte  <= `FSR_RST_BYTE;
      state_q.secondByte <= `FSR_RST_BYTE;
    end else begin
      state_q <= state_d;
    end
  end

  // ============================================================
  // Serial output
  // The byte loaded is the one selected before the toggle, so the
  // stream runs first, second, first, second while select is low
  assign loadByte = state_q.byteSel ? state_q.secondByte : state_q.firstByte;

  fsr_byte_shifter u_shifter (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .load     (state_q.loadReq),
    .loadData (loadByte),
    .shift    (state_q.shiftReq),
    .serOut   (so)
  );

  // Output driven only while a status read is under way
  assign soEn = (state_q.phase == fsr_pkg::PH_STATUS) & ~csN;

  // ============================================================
  // Buffer write gating for suspended programs
  assign bufWrAccept1 = bufWrReq1 & ~state_q.suspBuf1;
  assign bufWrAccept2 = bufWrReq2 & ~state_q.suspBuf2;

  // ============================================================
  // Parallel status copies
  assign statusFirst  = state_q.firstByte;
  assign statusSecond = state_q.secondByte;

endmodule : fsr_flash_status_register

// File: verif/fsr_status_monitor.sv
`timescale 1ns/1ps
module fsr_status_monitor #(
  parameter logic [3:0] DENSITY_CODE = 4'hA
) (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       csN,
  input wire logic       soEn,
  input wire logic       opBusy,
  input wire logic       opDone,
  input wire logic       opFailed,
  input wire logic       opAborted,
  input wire logic       cmpDone,
  input wire logic       cmpMismatch,
  input wire logic       protectSw,
  input wire logic       protectHw,
  input wire logic       lockFreeze,
  input wire logic       progSuspend1,
  input wire logic       progSuspend2,
  input wire logic       eraseSuspend,
  input wire logic       bufWrAccept1,
  input wire logic       bufWrAccept2,
  input wire logic [7:0] statusFirst,
  input wire logic [7:0] statusSecond
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ============================================================
  // Status bits against their causes
  a_ready_mirror: assert property ($past(rstn) |->
    statusSecond[7] == !$past(opBusy) && statusFirst[7] == !$past(opBusy)) else $error("ready bad");
  a_reserved_zero: assert property (!statusSecond[6] && !statusSecond[4])
    else $error("reserved bit set");
  a_fail_capture: assert property (opDone && !opAborted |=> statusSecond[5] == $past(opFailed))
    else $error("failure flag bad");
  a_abort_clear: assert property (opDone && opAborted |=> !statusSecond[5])
    else $error("abort set failure");
  a_fail_hold: assert property (!opDone |=> $stable(statusSecond[5]))
    else $error("failure flag moved");
  a_lock_gone: assert property (lockFreeze |=> !statusSecond[3] [*8])
    else $error("lockdown flag back");
  a_susp2_gate: assert property (progSuspend2 |=> statusSecond[2] && !bufWrAccept2)
    else $error("buffer two gate");
  a_susp1_gate: assert property (progSuspend1 |=> statusSecond[1] && !bufWrAccept1)
    else $error("buffer one gate");
  a_erase_susp: assert property (eraseSuspend |=> statusSecond[0])
    else $error("erase suspend flag");
  a_cmp_capture: assert property (cmpDone |=> statusFirst[6] == $past(cmpMismatch))
    else $error("compare flag bad");
  a_byte_one: assert property ($past(rstn) |-> statusFirst[5:2] == DENSITY_CODE
    && statusFirst[1] == ($past(protectSw) | $past(protectHw))) else $error("byte one bad");
  a_idle_quiet: assert property (csN |-> !soEn) else $error("so enabled while idle");
  a_frame_start: assert property ($fell(csN) |-> !soEn)
    else $error("so enabled at frame start");
endmodule : fsr_status_monitor

// File: verif/fsr_spi_host.sv
`timescale 1ns/1ps
module fsr_spi_host (
  input wire logic clk_sys,
  input wire logic so,
  input wire logic soEn,
  output logic     csN,
  output logic     sck,
  output logic     si
);
  // ============================================================
  // Mode 0 master, sck stands low between frames
  initial begin
    csN = 1'h1;
    sck = 1'h0;
    si  = 1'h0;
  end
  // Each sck level lasts 4 clk so the oversampled slave sees every edge
  // Repeated reads are how a caller polls for ready
  task automatic xfer(input logic [7:0] op, input int nBytes, output logic [23:0] rx,
                      output logic en);
    rx = 24'h000000;
    en = 1'h0;
    @(negedge clk_sys);
    csN = 1'h0;
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 8 + 8 * nBytes; i++) begin
      sck = 1'h0;
      si  = (i < 8) ? op[7 - i] : ~si;
      repeat (4) @(negedge clk_sys);
      sck = 1'h1;
      if (i >= 8) begin
        rx = {rx[22:0], so};
        en = en | soEn;
      end
      repeat (4) @(negedge clk_sys);
    end
    sck = 1'h0;
    repeat (4) @(negedge clk_sys);
    csN = 1'h1;
    repeat (2) @(negedge clk_sys);
  endtask : xfer
endmodule : fsr_spi_host

// File: verif/fsr_flash_status_register_tb.sv
`timescale 1ns/1ps
module fsr_flash_status_register_tb;
  localparam logic [3:0] DENS = 4'h6; // Arbitrary code
  logic        clk_sys, rstn, csN, sck, si, so, soEn, opBusy, opDone, opFailed, opAborted;
  logic        cmpDone, cmpMismatch, protectSw, protectHw, pageBinary, lockFreeze;
  logic        progSuspend1, progResume1, progSuspend2, progResume2, eraseSuspend, eraseResume;
  logic        bufWrReq1, bufWrReq2, bufWrAccept1, bufWrAccept2, fl, cm, lk, s1, s2, es, en;
  logic [7:0]  statusFirst, statusSecond;
  logic [23:0] rx;
  logic [2:0]  ev;
  int          miscompares, compares, cycles, seed, r;

  fsr_flash_status_register #(.DENSITY_CODE(DENS)) DUT (.*);
  fsr_spi_host host (.clk_sys, .so, .soEn, .csN, .sck, .si);

  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ============================================================
  // Expected bytes
  function automatic logic [7:0] exp_first();
    return {~opBusy, cm, DENS, protectSw | protectHw, pageBinary};
  endfunction : exp_first
  function automatic logic [7:0] exp_second();
    return {~opBusy, 1'h0, fl, 1'h0, lk, s2, s1, es};
  endfunction : exp_second
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic do_reset();
    rstn = 1'h0;
    repeat (2) @(negedge clk_sys);
    check("inReset", {statusFirst, statusSecond}, 16'h0000);
    rstn = 1'h1;
    {fl, cm, lk, s1, s2, es} = 6'h08;
    @(negedge clk_sys);
    check("resetFirst", statusFirst, exp_first());
    check("resetSecond", statusSecond, exp_second());
  endtask : do_reset
  // ============================================================
  // Main sequence
  initial begin
    seed = 28528;
    {opBusy, opDone, opFailed, opAborted, cmpDone, cmpMismatch, protectSw, protectHw} = 8'h00;
    {pageBinary, lockFreeze, progSuspend1, progResume1, progSuspend2, progResume2} = 6'h00;
    {eraseSuspend, eraseResume, bufWrReq1, bufWrReq2} = 4'h0;
    do_reset();
    for (int n = 0; n < 64; n++) begin
      r = $random(seed);
      {opBusy, protectSw, protectHw, pageBinary, bufWrReq1, bufWrReq2} = r[5:0];
      {opFailed, opAborted, cmpMismatch} = r[8:6];
      ev = r[11:9];
      // Suspend with resume in the same cycle: set must win
      {opDone, cmpDone, progSuspend1, progSuspend2, eraseSuspend} = 5'h00;
      {opDone, cmpDone} = {ev == 3'h0, ev == 3'h1};
      {progSuspend1, progResume1} = {ev == 3'h2, ev == 3'h3 || (ev == 3'h2 && r[12])};
      {progSuspend2, progResume2} = {ev == 3'h4, ev == 3'h5 || (ev == 3'h4 && r[12])};
      {eraseSuspend, eraseResume} = {ev == 3'h6, ev == 3'h7 || (ev == 3'h6 && r[12])};
      lockFreeze = (n == 40);
      if (opDone) fl = opFailed & ~opAborted;
      if (cmpDone) cm = cmpMismatch;
      if (lockFreeze) lk = 1'h0;
      s1 = progSuspend1 | (s1 & ~progResume1);
      s2 = progSuspend2 | (s2 & ~progResume2);
      es = eraseSuspend | (es & ~eraseResume);
      @(negedge clk_sys);
      {opDone, cmpDone, lockFreeze, progSuspend1, progResume1, progSuspend2} = 6'h00;
      {progResume2, eraseSuspend, eraseResume} = 3'h0;
      check("first", statusFirst, exp_first());
      check("second", statusSecond, exp_second());
      check("accept1", bufWrAccept1, bufWrReq1 & ~s1);
      check("accept2", bufWrAccept2, bufWrReq2 & ~s2);
      if (n % 4 == 0) begin
        host.xfer(8'hD7, 3, rx, en);
        check("stream", rx, {exp_first(), exp_second(), exp_first()});
        check("enable", en, 1'h1);
      end
    end
    // Poll both bytes four times, ready rising at the third, as a host waits out an operation
    for (int k = 0; k < 4; k++) begin
      opBusy = (k < 2);
      host.xfer(8'hD7, 2, rx, en);
      check("poll", rx[15:0], {exp_first(), exp_second()});
    end
    do_reset();
    host.xfer(8'h9F, 1, rx, en);
    check("refused", en, 1'h0);
    tally_and_finish();
  end
endmodule : fsr_flash_status_register_tb

bind fsr_flash_status_register fsr_status_monitor #(.DENSITY_CODE(DENSITY_CODE)) mon (
  .clk_sys, .rstn, .csN, .soEn, .opBusy, .opDone, .opFailed, .opAborted, .cmpDone,
  .cmpMismatch, .protectSw, .protectHw, .lockFreeze, .progSuspend1, .progSuspend2,
  .eraseSuspend, .bufWrAccept1, .bufWrAccept2, .statusFirst, .statusSecond);
